// *** low_speed_timer_control.sv ***
// Tilt-35 validation timer and event-pin temporary latch on a 10 Hz tick
//
// Notes on behaviour
// - Both durations count 10 Hz low-speed ticks.
// - Tilt code selects 1.6 s to 3.0 s.
// - Latch code selects 200 ms doubling, 6400 ms.
// - Latch active only while bit 7 set.
// - Control register resets to zero, host-written.
`timescale 1ns/10ps

module low_speed_timer_control
    import low_speed_timer_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Register write port
    input  wire logic       regWrite,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    // Detector side
    input  wire logic       tiltCondition,
    input  wire logic       eventIn,
    // Results
    output logic            tiltValid,
    output logic            eventOut,
    output logic [7:0]      controlValue
);

    localparam int TICK_WIDTH = $clog2(TICK_CYCLES_P + 1);
    localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(TICK_CYCLES_P - 1);

    // Tilt duration code to tick count
    function automatic logic [4:0] tiltTicks(input logic [2:0] code);
        tiltTicks = TILT_BASE_TICKS + 5'(code) * TILT_STEP_TICKS;
    endfunction

    // Latch period code to tick count; reserved codes clamp to the longest
    function automatic logic [6:0] latchTicks(input logic [2:0] code);
        logic [2:0] shift;
        shift = (code > LATCH_MAX_CODE) ? LATCH_MAX_CODE : code;
        latchTicks = LATCH_BASE_TICKS << shift;
    endfunction

    timer_ctrl_type        ctrl_ff;
    logic [TICK_WIDTH-1:0] prescale_ff;
    logic                  tick_ff;
    logic                  tiltPrev_ff;
    logic [4:0]            tiltCount_ff;
    logic                  tiltValid_ff;
    logic                  latchActive_ff;
    logic [6:0]            latchCount_ff;
    logic                  eventOut_ff;
    logic                  nxt_latchActive;
    logic [6:0]            nxt_latchCount;
    logic [4:0]            tiltTarget;
    logic [6:0]            latchTarget;
    logic                  tiltRise;

    assign tiltTarget   = tiltTicks(ctrl_ff.tiltDuration);
    assign latchTarget  = latchTicks(ctrl_ff.latchPeriod);
    assign tiltRise     = tiltCondition && !tiltPrev_ff;
    assign tiltValid    = tiltValid_ff;
    assign eventOut     = eventOut_ff;
    assign controlValue = ctrl_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_ff <= timer_ctrl_type'(CTRL_RESET_VALUE);
        end else if (regWrite && regAddr == CTRL_OFFSET) begin
            ctrl_ff <= timer_ctrl_type'(regWdata);
        end
    end

    // low-speed tick generator
    // Shared free-running divider: a restart may see its first tick early
    always_ff @(posedge clock) begin
        if (reset || prescale_ff == TICK_LAST) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (prescale_ff == TICK_LAST);
        end
    end

    // Tilt condition edge tracking
    always_ff @(posedge clock) begin
        if (reset) begin
            tiltPrev_ff <= 1'b0;
        end else begin
            tiltPrev_ff <= tiltCondition;
        end
    end

    // tilt count restart
    // Saturates at the target so a shorter code written later still validates
    always_ff @(posedge clock) begin
        if (reset || tiltRise || !tiltCondition) begin
            tiltCount_ff <= '0;
        end else if (tick_ff && tiltCount_ff < tiltTarget) begin
            tiltCount_ff <= tiltCount_ff + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tiltValid_ff <= 1'b0;
        end else begin
            tiltValid_ff <= tiltCondition && !tiltRise && (tiltCount_ff >= tiltTarget);
        end
    end

    // latch period sequencing
    // Events arriving while latched are absorbed until the period ends
    always_comb begin
        nxt_latchActive = latchActive_ff;
        nxt_latchCount  = latchCount_ff;
        if (!ctrl_ff.latchFeatureEnable) begin
            nxt_latchActive = 1'b0;
            nxt_latchCount  = '0;
        end else if (!latchActive_ff && eventIn) begin
            nxt_latchActive = 1'b1;
            nxt_latchCount  = '0;
        end else if (latchActive_ff && latchCount_ff >= latchTarget) begin
            // A shorter period written mid-latch ends it at once
            nxt_latchActive = 1'b0;
            nxt_latchCount  = '0;
        end else if (latchActive_ff && tick_ff) begin
            if (latchCount_ff + 7'h01 >= latchTarget) begin
                nxt_latchActive = 1'b0;
                nxt_latchCount  = '0;
            end else begin
                nxt_latchCount = latchCount_ff + 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            latchActive_ff <= 1'b0;
            latchCount_ff  <= '0;
        end else begin
            latchActive_ff <= nxt_latchActive;
            latchCount_ff  <= nxt_latchCount;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            eventOut_ff <= 1'b0;
        end else if (ctrl_ff.latchFeatureEnable) begin
            eventOut_ff <= nxt_latchActive;
        end else begin
            eventOut_ff <= eventIn;
        end
    end

    // Checks on the timing behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence tiltOnset;
        tiltCondition && !tiltPrev_ff;
    endsequence

    sequence latchStart;
        ctrl_ff.latchFeatureEnable && !latchActive_ff && eventIn;
    endsequence

    sequence latchLastTick;
        ctrl_ff.latchFeatureEnable && latchActive_ff && tick_ff && latchCount_ff + 7'h01 >= latchTarget;
    endsequence

    sequence latchHolding;
        ctrl_ff.latchFeatureEnable && latchActive_ff && !tick_ff && latchCount_ff < latchTarget;
    endsequence

    AST_CTRL_WRITE: assert property (regWrite && regAddr == CTRL_OFFSET |=> controlValue == $past(regWdata))
        else $error("control write not stored");
    AST_CTRL_HOLD: assert property (!(regWrite && regAddr == CTRL_OFFSET) |=> $stable(controlValue))
        else $error("control changed without write");
    AST_TILT_RESTART: assert property (tiltOnset |=> tiltCount_ff == 5'h00 && !tiltValid)
        else $error("tilt count did not restart");
    AST_TILT_VALID: assert property (tiltValid |-> $past(tiltCondition) && $past(tiltCount_ff) >= $past(tiltTarget))
        else $error("tilt valid too early");
    AST_TILT_TICK: assert property ($rose(tiltCount_ff != 5'h00) |-> $past(tick_ff))
        else $error("tilt count advanced without tick");
    AST_LATCH_START: assert property (latchStart |=> latchActive_ff && eventOut)
        else $error("latch did not start");
    // A period rewrite may leave the count past target for one cycle
    AST_LATCH_BOUND: assert property (latchActive_ff && $stable(latchTarget) |-> latchCount_ff < latchTarget)
        else $error("latch count beyond period");
    AST_LATCH_OFF: assert property (!ctrl_ff.latchFeatureEnable |=> eventOut == $past(eventIn))
        else $error("event not passed through when disabled");

    // Tick alignment, tilt levels and latch sequencing
    AST_TICK_WRAP: assert property (tick_ff |-> prescale_ff == '0)
        else $error("tick not aligned with divider wrap");
    AST_TILT_SET: assert property (tiltCondition && !tiltRise && tiltCount_ff >= tiltTarget |=> tiltValid)
        else $error("tilt valid missing after duration");
    AST_TILT_DROP: assert property (tiltValid && !tiltCondition |=> !tiltValid)
        else $error("tilt valid held after condition dropped");
    AST_TILT_CLEAR: assert property (!tiltCondition |=> tiltCount_ff == 5'h00)
        else $error("tilt count kept without condition");
    AST_LATCH_END: assert property (latchLastTick |=> !latchActive_ff && !eventOut)
        else $error("latch did not end on its last tick");
    AST_LATCH_KEEP: assert property (latchHolding |=> latchActive_ff && eventOut)
        else $error("latch dropped before its period");
    AST_LATCH_DROP: assert property (!ctrl_ff.latchFeatureEnable |=> !latchActive_ff)
        else $error("latch kept while disabled");

endmodule

// *** low_speed_timer_control_tb_top.sv ***
// Self-checking bench for the low-speed timer control block
`timescale 1ns/10ps

module low_speed_timer_control_tb_top;
    // Short tick keeps latch and tilt runs brief
    localparam int T = 8;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       tiltCondition = 1'b0;
    logic       eventIn = 1'b0;
    logic       tiltValid;
    logic       eventOut;
    logic [7:0] controlValue;
    logic [9:0] expQ[$];
    logic [9:0] got;
    logic [9:0] want;
    logic [7:0] ctrl = 8'h00;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         seed;

    low_speed_timer_control #(.TICK_CYCLES_P(T)) u_low_speed_timer_control (
        .clock(clock), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .tiltCondition(tiltCondition), .eventIn(eventIn),
        .tiltValid(tiltValid), .eventOut(eventOut), .controlValue(controlValue));

    // 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Expected outputs, judged at the next falling edge
    task automatic note(input int t, input int e);
        expQ.push_back({1'(t), 1'(e), ctrl});
    endtask

    // Second edge keeps back-to-back strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        if (a == 8'h4a) ctrl = d;
        @(posedge clock);
    endtask

    task automatic waitLvl(input int onEvent, input logic v, input int lim);
        repeat (lim) begin
            @(negedge clock);
            if ((onEvent ? eventOut : tiltValid) === v) break;
        end
    endtask

    task automatic report_and_stop();
        $display("Checks: %0d, mismatches: %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Output watcher, off the sampling edge
    always @(negedge clock) begin
        while (expQ.size() > 0) begin
            got = {tiltValid, eventOut, controlValue};
            want = expQ.pop_front();
            cmp_count++;
            if (got !== want) begin
                mismatches++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
            end
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        seed = $urandom(43);
        step(5);
        reset <= 1'b0;
        note(0, 0);
        wr(8'h4b + 8'($urandom_range(0, 200)), 8'($urandom));
        note(0, 0);
        wr(8'h4a, 8'($urandom) & 8'h7f);
        note(0, 0);
        for (int c = 0; c < 8; c++) begin
            wr(8'h4a, {ctrl[7:3], 3'(c)});
            tiltCondition <= 1'b1;
            step((15 + 2 * c) * T - 2);
            note(0, 0);
            waitLvl(0, 1'b1, T + 8);
            note(1, 0);
            @(posedge clock);
            tiltCondition <= 1'b0;
            step(2);
            note(0, 0);
        end
        wr(8'h4a, 8'h00);
        eventIn <= 1'b1;
        @(posedge clock);
        eventIn <= 1'b0;
        note(0, 1);
        @(posedge clock);
        note(0, 0);
        for (int c = 0; c < 6; c++) begin
            wr(8'h4a, {1'b1, 3'(c), 4'h0} | (8'($urandom) & 8'h0f));
            eventIn <= 1'b1;
            @(posedge clock);
            eventIn <= 1'b0;
            note(0, 1);
            step((2 << c) * T - T - 2);
            eventIn <= 1'b1; // ignored while latched
            note(0, 1);
            @(posedge clock);
            eventIn <= 1'b0;
            waitLvl(1, 1'b0, T + 6);
            note(0, 0);
            @(posedge clock);
        end
        eventIn <= 1'b1;
        @(posedge clock);
        eventIn <= 1'b0;
        step(4);
        note(0, 1);
        wr(8'h4a, 8'h00);
        note(0, 0);
        // mid-run reset clears the control register
        wr(8'h4a, 8'($urandom) | 8'h08);
        note(0, 0);
        reset <= 1'b1;
        ctrl = 8'h00;
        step(2);
        reset <= 1'b0;
        note(0, 0);
        wr(8'h4a, 8'h5c);
        note(0, 0);
        step(3);
        report_and_stop();
    end
endmodule

// *** low_speed_timer_pkg.sv ***
// Constants and types for the low-speed timer control block
package low_speed_timer_pkg;

    // Register map
    localparam logic [7:0] CTRL_OFFSET       = 8'h4a;
    localparam logic [7:0] CTRL_RESET_VALUE  = 8'h00;

    // Field positions inside the control register
    localparam int         LATCH_ENABLE_BIT  = 7;
    localparam int         LATCH_PERIOD_LSB  = 4;
    localparam int         TILT_DURATION_LSB = 0;

    // Low-speed tick timing
    localparam int         CLOCK_HZ          = 100_000_000;
    localparam int         SLOW_CLOCK_HZ     = 10;
    localparam int         TICK_CYCLES       = CLOCK_HZ / SLOW_CLOCK_HZ;

    // Duration encodings in low-speed ticks
    localparam logic [4:0] TILT_BASE_TICKS   = 5'h10;
    localparam logic [4:0] TILT_STEP_TICKS   = 5'h02;
    localparam logic [6:0] LATCH_BASE_TICKS  = 7'h02;
    localparam logic [2:0] LATCH_MAX_CODE    = 3'h5;

    // Control register layout
    typedef struct packed {
        logic       latchFeatureEnable;
        logic [2:0] latchPeriod;
        logic       reserved;
        logic [2:0] tiltDuration;
    } timer_ctrl_type;

endpackage
